// [design/clem_map.svh]
// Purpose: Constants for the configurable logic element
// Assumes: 25 MHz system clock
// Notes: Offsets do not exist; all config is on plain ports
`ifndef CLEM_MAP_SVH
`define CLEM_MAP_SVH
`define CLEM_CLK_HZ 25000000
`define CLEM_MS_PER_S 1000
`define CLEM_CYC_PER_MS (`CLEM_CLK_HZ / `CLEM_MS_PER_S)
`define CLEM_PULSE_MS 20
`define CLEM_N_IN 16
`define CLEM_GCNT_W 5
`define CLEM_DLY_W 16
`define CLEM_CTR_W 16
`define CLEM_LATCH_RST 1'b0
`define CLEM_OUT_RST 1'b0
`endif

// [design/clem_pkg.sv]
// Purpose: Types for the configurable logic element
// Assumes: Widths from clem_map.svh
// Notes: Group counts pick consecutive input slots A, B, C, D
`include "clem_map.svh"
package clem_pkg;
	typedef enum logic [3:0] {
		G_AND = 4'h0,
		G_OR = 4'h1,
		G_XOR = 4'h2,
		G_AND_OR = 4'h3,
		G_INVERTED_INPUT_AND = 4'h4,
		G_INVERTED_INPUT_OR = 4'h5,
		G_COUNTER_GATE = 4'h6,
		G_SR_LATCH = 4'h7,
		G_SET_DATA_LOAD_LATCH = 4'h8,
		G_PULSE_RISE_POS = 4'h9,
		G_PULSE_RISE_NEG = 4'hA,
		G_PULSE_FALL_POS = 4'hB,
		G_PULSE_FALL_NEG = 4'hC,
		G_PULSE_ANY_POS = 4'hD,
		G_PULSE_ANY_NEG = 4'hE
	} clem_gate_t;
	typedef enum logic [1:0] {
		DLY_IDLE = 2'b00,
		DLY_ON_WAIT = 2'b01,
		DLY_ACTIVE = 2'b10,
		DLY_OFF_WAIT = 2'b11
	} clem_dly_t;
	// Element settings as loaded from the settings store
	typedef struct packed {
		clem_gate_t gate;
		logic invert;
		logic reverse;
		logic [`CLEM_DLY_W-1:0] on_delay_ms;
		logic [`CLEM_DLY_W-1:0] off_delay_ms;
		logic [`CLEM_CTR_W-1:0] count_setting;
		logic [`CLEM_GCNT_W-1:0] grp_a_cnt;
		logic [`CLEM_GCNT_W-1:0] grp_b_cnt;
		logic [`CLEM_GCNT_W-1:0] grp_c_cnt;
		logic [`CLEM_GCNT_W-1:0] grp_d_cnt;
	} clem_cfg_t;
endpackage

// [design/clem_ms_timer.sv]
// Purpose: Millisecond interval timer with its own tick prescaler
// Assumes: start and abort come from logic on the same clock
// Notes: Prescaler restarts on start, so intervals are exact
`timescale 1ns/100ps
`include "clem_map.svh"
module clem_ms_timer #(
	parameter int CYC_PER_MS = `CLEM_CYC_PER_MS,
	parameter int DUR_W = `CLEM_DLY_W
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	input wire logic abort,
	input wire logic [DUR_W-1:0] duration,
	output logic running
);
	localparam int PRE_W = $clog2(CYC_PER_MS);
	localparam logic [PRE_W-1:0] PRE_TOP = PRE_W'(CYC_PER_MS - 1);
	logic [PRE_W-1:0] pre;
	logic [DUR_W-1:0] ms_left;
	// One millisecond tick while running
	wire tick = running && (pre == '0);
	wire last_ms = ms_left == DUR_W'(1);
	// Running stays high duration times CYC_PER_MS cycles
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			running <= 1'b0;
			pre <= '0;
			ms_left <= '0;
		end else if (abort) begin
			running <= 1'b0;
		end else if (start) begin
			running <= (duration != '0);
			pre <= PRE_TOP;
			ms_left <= duration;
		end else if (tick) begin
			pre <= PRE_TOP;
			ms_left <= ms_left - 1'b1;
			running <= !last_ms;
		end else if (running) begin
			pre <= pre - 1'b1;
		end
	end
endmodule

// [design/clem_element.sv]
// Purpose: One configurable logic element of a protection relay
// Assumes: Settings are static while the element runs
// Notes: Inputs are asynchronous pins and are synchronised first
`timescale 1ns/100ps
`include "clem_map.svh"
module clem_element import clem_pkg::*; #(
	parameter int N_IN = `CLEM_N_IN,
	parameter int CYC_PER_MS = `CLEM_CYC_PER_MS
) (
	input wire logic SYS_CLK,
	input wire logic RST,
	input wire logic [N_IN-1:0] LOGIC_IN,
	input clem_cfg_t CFG,
	output logic ELEMENT_OUT,
	output logic [`CLEM_CTR_W-1:0] COUNT_VALUE
);
	localparam int SUM_W = `CLEM_GCNT_W + 2;
	localparam int PULSE_CYC = `CLEM_PULSE_MS * CYC_PER_MS;
	localparam logic [`CLEM_DLY_W-1:0] PULSE_MS = `CLEM_DLY_W'(`CLEM_PULSE_MS);

	// Refuse sizes the group decode or prescaler cannot serve
	if (N_IN < 1 || N_IN > (1 << `CLEM_GCNT_W) - 1) begin : g_bad_n
		$error("N_IN out of range");
	end
	if (CYC_PER_MS < 2) begin : g_bad_cyc
		$error("CYC_PER_MS must be at least 2");
	end

	logic [N_IN-1:0] in_meta;
	logic [N_IN-1:0] in_sync;
	logic a_prev;
	logic latch_q;
	clem_dly_t dly_state;
	clem_dly_t next_dly;
	logic raw_cond;
	logic dly_start;
	logic dly_abort;
	logic dly_running;
	logic pulse_run;
	logic [N_IN-1:0] mask_a;
	logic [N_IN-1:0] mask_b;
	logic [N_IN-1:0] mask_c;
	logic [N_IN-1:0] mask_d;

	// Two-stage synchroniser on the element inputs
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			in_meta <= '0;
			in_sync <= '0;
		end else begin
			in_meta <= LOGIC_IN;
			in_sync <= in_meta;
		end
	end

	// Group boundaries: A, B, C, D occupy consecutive slots
	wire [SUM_W-1:0] end_a = SUM_W'(CFG.grp_a_cnt);
	wire [SUM_W-1:0] end_b = end_a + SUM_W'(CFG.grp_b_cnt);
	wire [SUM_W-1:0] end_c = end_b + SUM_W'(CFG.grp_c_cnt);
	wire [SUM_W-1:0] end_d = end_c + SUM_W'(CFG.grp_d_cnt);
	for (genvar i = 0; i < N_IN; i++) begin : g_mask
		assign mask_a[i] = SUM_W'(i) < end_a;
		assign mask_b[i] = (SUM_W'(i) >= end_a) && (SUM_W'(i) < end_b);
		assign mask_c[i] = (SUM_W'(i) >= end_b) && (SUM_W'(i) < end_c);
		assign mask_d[i] = (SUM_W'(i) >= end_c) && (SUM_W'(i) < end_d);
	end

	// Per-group reductions; empty AND groups read as true
	wire any_a = |(in_sync & mask_a);
	wire all_a = &(in_sync | ~mask_a);
	wire xor_a = ^(in_sync & mask_a);
	wire any_b = |(in_sync & mask_b);
	wire all_b = &(in_sync | ~mask_b);
	wire any_b_inv = |(~in_sync & mask_b);
	wire all_b_inv = &(~in_sync | ~mask_b);
	wire any_c = |(in_sync & mask_c);
	wire any_d = |(in_sync & mask_d);

	// Combined gate: A feeds the first stage, B joins the second
	wire and_or = CFG.reverse ? (any_a & all_b) : (all_a | any_b);
	// Normal inputs in A, inverted inputs in B
	wire inv_and = all_a & all_b_inv;
	wire inv_or = any_a | any_b_inv;

	// Edge detect on the OR of group A for pulses and counting
	wire a_rise = any_a & ~a_prev;
	wire a_fall = ~any_a & a_prev;
	wire pulse_rise_type = (CFG.gate == G_PULSE_RISE_POS) || (CFG.gate == G_PULSE_RISE_NEG);
	wire pulse_fall_type = (CFG.gate == G_PULSE_FALL_POS) || (CFG.gate == G_PULSE_FALL_NEG);
	wire pulse_any_type = (CFG.gate == G_PULSE_ANY_POS) || (CFG.gate == G_PULSE_ANY_NEG);
	wire pulse_trig = (pulse_rise_type & a_rise) | (pulse_fall_type & a_fall)
		| (pulse_any_type & (a_rise | a_fall));

	// Pulse width timer; a new edge restarts the full width
	clem_ms_timer #(
		.CYC_PER_MS(CYC_PER_MS),
		.DUR_W(`CLEM_DLY_W)
	) u_pulse_timer (
		.clk(SYS_CLK),
		.rst(RST),
		.start(pulse_trig),
		.abort(1'b0),
		.duration(PULSE_MS),
		.running(pulse_run)
	);

	// Counter gate: rising edges of A count, any B input clears
	wire ctr_type = CFG.gate == G_COUNTER_GATE;
	wire ctr_clear = ctr_type & any_b;
	wire ctr_inc = ctr_type & a_rise & (COUNT_VALUE != '1);
	wire ctr_hit = COUNT_VALUE >= CFG.count_setting;

	// Latches: reset always wins, a stored one only leaves on reset
	wire sr_type = CFG.gate == G_SR_LATCH;
	wire sdl_type = CFG.gate == G_SET_DATA_LOAD_LATCH;
	wire latch_rst = sr_type ? any_b : any_d;
	wire latch_load = sdl_type & any_c & any_b;
	wire next_latch = (sr_type | sdl_type) & ~latch_rst & (any_a | latch_load | latch_q);

	// Element bookkeeping registers
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			a_prev <= 1'b0;
			latch_q <= `CLEM_LATCH_RST;
			COUNT_VALUE <= '0;
		end else begin
			a_prev <= any_a;
			latch_q <= next_latch;
			if (ctr_clear) begin
				COUNT_VALUE <= '0;
			end else if (ctr_inc) begin
				COUNT_VALUE <= COUNT_VALUE + 1'b1;
			end
		end
	end

	// Gate function select; code 4'hF is unused and reads false
	always_comb begin
		raw_cond = 1'b0;
		unique case (CFG.gate)
			G_AND: raw_cond = all_a;
			G_OR: raw_cond = any_a;
			G_XOR: raw_cond = xor_a;
			G_AND_OR: raw_cond = and_or;
			G_INVERTED_INPUT_AND: raw_cond = inv_and;
			G_INVERTED_INPUT_OR: raw_cond = inv_or;
			G_COUNTER_GATE: raw_cond = ctr_hit;
			G_SR_LATCH: raw_cond = latch_q;
			G_SET_DATA_LOAD_LATCH: raw_cond = latch_q;
			G_PULSE_RISE_POS, G_PULSE_FALL_POS, G_PULSE_ANY_POS: raw_cond = pulse_run;
			G_PULSE_RISE_NEG, G_PULSE_FALL_NEG, G_PULSE_ANY_NEG: raw_cond = ~pulse_run;
			default: raw_cond = 1'b0;
		endcase
	end

	// ON/OFF delay sequencer; one timer serves both waits
	wire on_zero = CFG.on_delay_ms == '0;
	wire off_zero = CFG.off_delay_ms == '0;
	wire [`CLEM_DLY_W-1:0] dly_dur = (dly_state == DLY_IDLE) ? CFG.on_delay_ms : CFG.off_delay_ms;
	always_comb begin
		next_dly = dly_state;
		dly_start = 1'b0;
		dly_abort = 1'b0;
		unique case (dly_state)
			DLY_IDLE: if (raw_cond) begin
				next_dly = on_zero ? DLY_ACTIVE : DLY_ON_WAIT;
				dly_start = ~on_zero;
			end
			DLY_ON_WAIT: if (!raw_cond) begin
				next_dly = DLY_IDLE;
				dly_abort = 1'b1;
			end else if (!dly_running) begin
				next_dly = DLY_ACTIVE;
			end
			DLY_ACTIVE: if (!raw_cond) begin
				next_dly = off_zero ? DLY_IDLE : DLY_OFF_WAIT;
				dly_start = ~off_zero;
			end
			DLY_OFF_WAIT: if (raw_cond) begin
				next_dly = DLY_ACTIVE;
				dly_abort = 1'b1;
			end else if (!dly_running) begin
				next_dly = DLY_IDLE;
			end
		endcase
	end

	clem_ms_timer #(
		.CYC_PER_MS(CYC_PER_MS),
		.DUR_W(`CLEM_DLY_W)
	) u_delay_timer (
		.clk(SYS_CLK),
		.rst(RST),
		.start(dly_start),
		.abort(dly_abort),
		.duration(dly_dur),
		.running(dly_running)
	);

	// Output flop: delayed state, then optional inversion
	wire next_active = (next_dly == DLY_ACTIVE) || (next_dly == DLY_OFF_WAIT);
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			dly_state <= DLY_IDLE;
			ELEMENT_OUT <= `CLEM_OUT_RST;
		end else begin
			dly_state <= next_dly;
			ELEMENT_OUT <= next_active ^ CFG.invert;
		end
	end

	// Checker helpers: run lengths, only read by assertions
	int pulse_age;
	int cond_age;
	int nocond_age;
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			pulse_age <= 0;
			cond_age <= 0;
			nocond_age <= 0;
		end else begin
			pulse_age <= pulse_trig ? 0 : pulse_age + 1;
			cond_age <= raw_cond ? cond_age + 1 : 0;
			nocond_age <= raw_cond ? 0 : nocond_age + 1;
		end
	end
	wire integer on_cyc = int'(CFG.on_delay_ms) * CYC_PER_MS;
	wire integer off_cyc = int'(CFG.off_delay_ms) * CYC_PER_MS;

	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RST);

	property p_pulse_width;
		$fell(pulse_run) |-> pulse_age == PULSE_CYC;
	endproperty
	a_pulse_width: assert property (p_pulse_width) else $error("pulse width wrong");
	property p_pos_start;
		(CFG.gate == G_PULSE_ANY_POS) && (a_rise || a_fall) |=> raw_cond ##1 raw_cond;
	endproperty
	a_pos_start: assert property (p_pos_start) else $error("positive pulse missing");
	property p_neg_start;
		(CFG.gate == G_PULSE_ANY_NEG) && (a_rise || a_fall) |=> !raw_cond ##1 !raw_cond;
	endproperty
	a_neg_start: assert property (p_neg_start) else $error("negative pulse missing");
	property p_invert;
		(dly_state == DLY_ACTIVE) && $stable(CFG.invert) && $past(dly_state) == DLY_ACTIVE
			|-> ELEMENT_OUT == !CFG.invert;
	endproperty
	a_invert: assert property (p_invert) else $error("inversion wrong");
	property p_on_delay;
		(dly_state == DLY_ON_WAIT) && (next_dly == DLY_ACTIVE) |-> cond_age == on_cyc + 1;
	endproperty
	a_on_delay: assert property (p_on_delay) else $error("ON delay length wrong");
	property p_off_delay;
		(dly_state == DLY_OFF_WAIT) && (next_dly == DLY_IDLE) |-> nocond_age == off_cyc + 1;
	endproperty
	a_off_delay: assert property (p_off_delay) else $error("OFF delay length wrong");
	property p_ctr_clear;
		ctr_clear |=> (COUNT_VALUE == '0);
	endproperty
	a_ctr_clear: assert property (p_ctr_clear) else $error("counter not cleared");
	property p_sr_reset;
		sr_type && any_b |=> !latch_q;
	endproperty
	a_sr_reset: assert property (p_sr_reset) else $error("reset did not clear latch");
	property p_sr_hold;
		sr_type && latch_q && !any_b |=> latch_q;
	endproperty
	a_sr_hold: assert property (p_sr_hold) else $error("latch lost its one");
	property p_sdl_hold;
		sdl_type && latch_q && !any_d |=> latch_q;
	endproperty
	a_sdl_hold: assert property (p_sdl_hold) else $error("stored one lost without reset");
endmodule

// [sim/clem_tb.sv]
// Purpose: Self-checking bench for the configurable logic element
// Assumes: Prescaler shortened to 4 cycles per millisecond
// Notes: Inputs and settings change on the falling edge only
`timescale 1ns/100ps
`include "clem_map.svh"
module testbench import clem_pkg::*;;
	localparam int CPM = 4;
	logic SYS_CLK;
	logic RST;
	logic [15:0] LOGIC_IN;
	clem_cfg_t CFG;
	logic ELEMENT_OUT;
	logic [`CLEM_CTR_W-1:0] COUNT_VALUE;
	int err_total = 0;
	int samples_checked = 0;
	int n;
	logic rest;

	clem_element #(.N_IN(16), .CYC_PER_MS(CPM)) dut_u (
		.SYS_CLK(SYS_CLK),
		.RST(RST),
		.LOGIC_IN(LOGIC_IN),
		.CFG(CFG),
		.ELEMENT_OUT(ELEMENT_OUT),
		.COUNT_VALUE(COUNT_VALUE)
	);

	// Free-running 25 MHz clock
	initial begin
		SYS_CLK = 1'b0;
		forever #20 SYS_CLK = ~SYS_CLK;
	end

	// Compare one value, four-state exact
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	// Verdict and end of run
	task automatic summarize();
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// New inputs, then hold for some cycles
	task automatic drive(input logic [15:0] v, input int cyc);
		@(negedge SYS_CLK);
		LOGIC_IN = v;
		repeat (cyc) @(negedge SYS_CLK);
	endtask

	// Gate check; six cycles cover synchroniser plus latch stage
	task automatic gc(input logic [15:0] v, input logic e);
		drive(v, 6);
		chk("element_out", ELEMENT_OUT, e);
	endtask

	// Edges until the output reaches a level; a hang ends the run
	task automatic wait_lvl(input logic lvl, input int lim, output int cnt);
		cnt = 0;
		while (ELEMENT_OUT !== lvl) begin
			@(negedge SYS_CLK);
			cnt++;
			if (cnt > lim) begin
				err_total++;
				$display("ERROR wait_level expected %0h seen %0h", lvl, ELEMENT_OUT);
				summarize();
			end
		end
	endtask

	// Load settings with zero delays and quiet inputs
	task automatic cfg(input clem_gate_t g, input logic inv, input logic rev, input int a, input int b,
			input int c, input int d);
		@(negedge SYS_CLK);
		CFG = '0;
		CFG.gate = g;
		CFG.invert = inv;
		CFG.reverse = rev;
		CFG.count_setting = 16'h0003;
		CFG.grp_a_cnt = 5'(a);
		CFG.grp_b_cnt = 5'(b);
		CFG.grp_c_cnt = 5'(c);
		CFG.grp_d_cnt = 5'(d);
		LOGIC_IN = 16'h0000;
		repeat (8) @(negedge SYS_CLK);
	endtask

	initial begin
		RST = 1'b1;
		CFG = '0;
		LOGIC_IN = 16'h0000;
		repeat (16) @(negedge SYS_CLK);
		chk("out_in_reset", ELEMENT_OUT, 0);
		chk("count_in_reset", COUNT_VALUE, 0);
		RST = 1'b0;
		// Odd parity over three inputs; bit 4 lies outside the group
		cfg(G_XOR, 0, 0, 3, 0, 0, 0);
		for (int i = 0; i < 8; i++) begin
			gc(16'(i) | 16'h0010, ^i[2:0]);
		end
		// AND stage on A, OR stage on B, then swapped
		cfg(G_AND_OR, 0, 0, 2, 2, 0, 0);
		gc(16'h0003, 1);
		gc(16'h0004, 1);
		gc(16'h0001, 0);
		cfg(G_AND_OR, 0, 1, 2, 2, 0, 0);
		gc(16'h0003, 0);
		gc(16'h000D, 1);
		gc(16'h000C, 0);
		// One normal input against two inverted ones, then against one
		cfg(G_INVERTED_INPUT_AND, 0, 0, 1, 2, 0, 0);
		gc(16'h0001, 1);
		gc(16'h0005, 0);
		gc(16'h0000, 0);
		cfg(G_INVERTED_INPUT_OR, 0, 0, 1, 1, 0, 0);
		gc(16'h0002, 0);
		gc(16'h0000, 1);
		// Inversion on a plain AND
		cfg(G_AND, 1, 0, 2, 0, 0, 0);
		gc(16'h0003, 0);
		gc(16'h0001, 1);
		// Inverted three-input OR; bit 3 lies outside the group
		cfg(G_OR, 1, 0, 3, 0, 0, 0);
		gc(16'h0004, 0);
		gc(16'h0008, 1);
		// Set/reset latch: reset wins, set is remembered
		cfg(G_SR_LATCH, 0, 0, 1, 1, 0, 0);
		gc(16'h0001, 1);
		gc(16'h0000, 1);
		gc(16'h0003, 0);
		gc(16'h0001, 1);
		gc(16'h0002, 0);
		gc(16'h0000, 0);
		// Set, data, load, reset on bits 0..3
		cfg(G_SET_DATA_LOAD_LATCH, 0, 0, 1, 1, 1, 1);
		gc(16'h0002, 0);
		gc(16'h0006, 1);
		gc(16'h0004, 1);
		gc(16'h0000, 1);
		gc(16'h0009, 0);
		gc(16'h0001, 1);
		gc(16'h0008, 0);
		// Counter reaches its setting of three, then clears
		cfg(G_COUNTER_GATE, 0, 0, 1, 1, 0, 0);
		for (int i = 1; i <= 3; i++) begin
			drive(16'h0001, 6);
			drive(16'h0000, 6);
			chk("count_value", COUNT_VALUE, i);
			chk("element_out", ELEMENT_OUT, i == 3);
		end
		gc(16'h0002, 0);
		chk("count_value", COUNT_VALUE, 0);
		// Any-edge pulses, both polarities, both edge directions
		for (int g = 0; g < 2; g++) begin
			cfg(g ? G_PULSE_ANY_NEG : G_PULSE_ANY_POS, 0, 0, 1, 0, 0, 0);
			rest = (g == 1);
			chk("pulse_rest", ELEMENT_OUT, rest);
			for (int k = 0; k < 2; k++) begin
				drive(k ? 16'h0000 : 16'h0001, 0);
				wait_lvl(~rest, 10, n);
				wait_lvl(rest, 100, n);
				chk("pulse_width", n, 20 * CPM);
			end
		end
		// Single-edge pulse types; the other edge leaves the output at rest
		for (int g = 0; g < 4; g++) begin
			cfg(clem_gate_t'(4'h9 + g), 0, 0, 1, 0, 0, 0);
			rest = g[0];
			for (int k = 0; k < 2; k++) begin
				drive(k ? 16'h0000 : 16'h0001, 0);
				if ((k == 1) == (g >= 2)) begin
					wait_lvl(~rest, 10, n);
					wait_lvl(rest, 100, n);
					chk("edge_pulse", n, 20 * CPM);
				end else begin
					repeat (10) @(negedge SYS_CLK);
					chk("edge_ignored", ELEMENT_OUT, rest);
				end
			end
		end
		// ON delay 2 ms, OFF delay 3 ms on a one-input AND
		cfg(G_AND, 0, 0, 1, 0, 0, 0);
		@(negedge SYS_CLK);
		CFG.on_delay_ms = 16'h0002;
		CFG.off_delay_ms = 16'h0003;
		// A condition shorter than the ON delay never shows
		drive(16'h0001, 6);
		chk("short_on", ELEMENT_OUT, 0);
		drive(16'h0000, 12);
		chk("short_on", ELEMENT_OUT, 0);
		drive(16'h0001, 0);
		wait_lvl(1, 40, n);
		// Three edges of input path, the wait, then one edge to leave it
		chk("on_delay", n, 2 * CPM + 4);
		drive(16'h0000, 0);
		wait_lvl(0, 40, n);
		chk("off_delay", n, 3 * CPM + 4);
		summarize();
	end
endmodule
